// ---- csu_pkg.sv ----
// Shared constants and carriers for the capability seal and unseal unit
`default_nettype none
package csu_pkg;

	// Datapath widths
	localparam int CSU_XLEN = 64;
	localparam int CSU_TYPE_W = 4;
	localparam int CSU_REG_IDX_W = 5;

	// Positions in the permissions bitfield
	localparam int CSU_TYPE_LOCK_GRANT_BIT = 24;
	localparam int CSU_TYPE_OPEN_GRANT_BIT = 25;
	localparam int CSU_PERM_ZERO_LO = 26;

	// Wide scope flag values
	localparam logic CSU_SCOPE_GLOBAL = 1'b1;
	localparam logic CSU_SCOPE_LOCAL = 1'b0;

	// Type value of an unsealed capability
	localparam logic [CSU_TYPE_W-1:0] CSU_TYPE_UNSEALED = 4'h0;

	// Number of distinct failure causes reported
	localparam int CSU_FAIL_W = 8;

	// Failure cause bit positions
	localparam int CSU_F_SRC_SEALED = 0;
	localparam int CSU_F_AUTH_UNTAGGED = 1;
	localparam int CSU_F_NO_LOCK_GRANT = 2;
	localparam int CSU_F_NO_OPEN_GRANT = 3;
	localparam int CSU_F_OUT_OF_BOUNDS = 4;
	localparam int CSU_F_TYPE_UNREP = 5;
	localparam int CSU_F_PERM_CONFLICT = 6;
	localparam int CSU_F_TYPE_MISMATCH = 7;

	// Values after reset
	localparam logic [CSU_REG_IDX_W-1:0] CSU_RD_RESET = 5'h00;
	localparam logic [CSU_FAIL_W-1:0] CSU_FAIL_RESET = 8'h00;

	// Operation selector
	typedef enum logic [1:0] {
		CSU_OP_NONE = 2'b00,
		CSU_OP_SEAL = 2'b01,
		CSU_OP_UNSEAL = 2'b11
	} csu_op_e;

	// Decoded capability as carried in the pipeline
	typedef struct packed {
		logic tag;
		logic wide_scope_flag;
		logic [CSU_XLEN-1:0] perms;
		logic [CSU_TYPE_W-1:0] type_label_field;
		logic [CSU_XLEN-1:0] base;
		logic [CSU_XLEN:0] top;
		logic [CSU_XLEN-1:0] addr;
	} csu_cap_s;

	// One request from the execute stage
	typedef struct packed {
		logic valid;
		csu_op_e op;
		logic [CSU_REG_IDX_W-1:0] rd;
		csu_cap_s rs1;
		csu_cap_s rs2;
	} csu_req_s;

	// One answer towards writeback
	typedef struct packed {
		logic valid;
		logic [CSU_REG_IDX_W-1:0] rd;
		csu_cap_s cap;
		logic [CSU_FAIL_W-1:0] fail;
	} csu_resp_s;

	localparam csu_cap_s CSU_CAP_RESET = '0;
	localparam csu_resp_s CSU_RESP_RESET = '0;

endpackage : csu_pkg
`default_nettype wire

// ---- csu_seal_unit.sv ----
// Capability seal and unseal datapath with registered writeback port
// What this block does
// - Seal copies rs2 into rd with type set to the rs1 address.
// - Seal clears result tag when rs2 already carries a non-zero type.
// - Seal fails on untagged or out-of-bounds authority, or no lock grant.
// - Seal fails when rs1 address is not a type the encoding represents.
// - Seal fails when rs2 permissions cannot validly carry a sealed type.
// - Unseal copies rs2 into rd with its type field set to zero.
// - Unseal fails on untagged or out-of-bounds authority, or no open grant.
// - Unseal fails unless rs1 address exactly equals the rs2 type.
// - With locality support, unseal result is local if rs1 or rs2 is local.
// - Lock grant at bit 24, open grant bit 25, bits 26 up read zero.
// - Sentry type values get no exemption from sealing or unsealing.
// - Wide scope flag is one bit, one meaning global, zero local.
`default_nettype none
module csu_seal_unit #(
	parameter bit LOCALITY_EN = 1'b1,
	// Largest type value the encoding can hold on a sealed capability
	parameter logic [csu_pkg::CSU_XLEN-1:0] TYPE_MAX = 64'h000000000000000f,
	// Permissions rs2 must grant to be sealed at any non-zero type
	parameter logic [csu_pkg::CSU_XLEN-1:0] SEAL_REQ_PERMS = 64'h0,
	// Permissions rs2 must not grant to be sealed at any non-zero type
	parameter logic [csu_pkg::CSU_XLEN-1:0] SEAL_BAN_PERMS = 64'h0
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// Request from the execute stage
	input wire csu_pkg::csu_req_s req_i,
	// Result towards the capability register file
	output csu_pkg::csu_resp_s resp_o,
	// Permissions bitfield of the result, as a permission read shows it
	output logic [csu_pkg::CSU_XLEN-1:0] resp_perm_view_o
);
	import csu_pkg::*;

	// Mask keeping only the defined permission bits
	localparam logic [CSU_XLEN-1:0] PERM_KEEP_MASK =
		(64'h1 << CSU_PERM_ZERO_LO) - 64'h1;

	csu_cap_s rs1;
	csu_cap_s rs2;
	logic is_seal;
	logic is_unseal;

	// Authority checks on rs1; lock grant is checked for seal only, open grant for unseal only
	logic auth_untagged;
	logic auth_out_of_bounds;
	logic auth_lock_grant;
	logic auth_open_grant;

	// Seal specific checks
	logic src_sealed;
	logic type_unrep;
	logic perm_conflict;

	// Unseal specific checks
	logic type_mismatch;

	logic [CSU_XLEN-1:0] rs2_perms_clean;
	logic [CSU_TYPE_W-1:0] new_type;
	logic [CSU_FAIL_W-1:0] fail_vec;
	logic new_scope;
	logic new_tag;

	csu_resp_s resp_reg;
	csu_resp_s resp_next;
	logic [CSU_XLEN-1:0] perm_view_reg;
	logic [CSU_XLEN-1:0] perm_view_next;

	assign rs1 = req_i.rs1;
	assign rs2 = req_i.rs2;
	assign is_seal = req_i.valid && (req_i.op == CSU_OP_SEAL);
	assign is_unseal = req_i.valid && (req_i.op == CSU_OP_UNSEAL);

	always_comb begin
		auth_untagged = !rs1.tag;
		// Top is one bit wider so a full-space authority still covers the
		// last address
		auth_out_of_bounds = (rs1.addr < rs1.base) ||
			({1'b0, rs1.addr} >= rs1.top);
		auth_lock_grant = rs1.perms[CSU_TYPE_LOCK_GRANT_BIT];
		auth_open_grant = rs1.perms[CSU_TYPE_OPEN_GRANT_BIT];
	end

	always_comb begin
		src_sealed = (rs2.type_label_field != CSU_TYPE_UNSEALED);
		// Zero is not a sealed type: sealing at it would yield an
		// unsealed result that looks like a success, so it is refused.
		// No range of values is set aside for sentries here.
		type_unrep = (rs1.addr == 64'h0) ||
			(rs1.addr > TYPE_MAX);
		perm_conflict = ((rs2.perms & SEAL_REQ_PERMS) != SEAL_REQ_PERMS) ||
			((rs2.perms & SEAL_BAN_PERMS) != 64'h0);
	end

	always_comb begin
		// Exact comparison over the full width; a wide authority range
		// gives no match on its own
		type_mismatch = (rs1.addr !=
			{{(CSU_XLEN-CSU_TYPE_W){1'b0}}, rs2.type_label_field});
	end

	always_comb begin
		fail_vec = CSU_FAIL_RESET;
		if (is_seal) begin
			fail_vec[CSU_F_SRC_SEALED] = src_sealed;
			fail_vec[CSU_F_AUTH_UNTAGGED] = auth_untagged;
			fail_vec[CSU_F_NO_LOCK_GRANT] = !auth_lock_grant;
			fail_vec[CSU_F_OUT_OF_BOUNDS] = auth_out_of_bounds;
			fail_vec[CSU_F_TYPE_UNREP] = type_unrep;
			fail_vec[CSU_F_PERM_CONFLICT] = perm_conflict;
		end else if (is_unseal) begin
			fail_vec[CSU_F_AUTH_UNTAGGED] = auth_untagged;
			fail_vec[CSU_F_NO_OPEN_GRANT] = !auth_open_grant;
			fail_vec[CSU_F_OUT_OF_BOUNDS] = auth_out_of_bounds;
			fail_vec[CSU_F_TYPE_MISMATCH] = type_mismatch;
		end
	end

	always_comb begin
		// Undefined upper permission bits never leak into a result
		rs2_perms_clean = rs2.perms & PERM_KEEP_MASK;
		new_type = rs2.type_label_field;
		new_scope = rs2.wide_scope_flag;
		if (is_seal) begin
			// Truncation only matters on failure, when the tag is gone
			new_type = rs1.addr[CSU_TYPE_W-1:0];
		end else if (is_unseal) begin
			new_type = CSU_TYPE_UNSEALED;
			if (LOCALITY_EN &&
				(rs1.wide_scope_flag == CSU_SCOPE_LOCAL)) begin
				new_scope = CSU_SCOPE_LOCAL;
			end
		end
		// A check failure only drops the tag; nothing is trapped
		new_tag = rs2.tag && (fail_vec == CSU_FAIL_RESET);
	end

	always_comb begin
		resp_next = resp_reg;
		perm_view_next = perm_view_reg;
		resp_next.valid = is_seal || is_unseal;
		if (is_seal || is_unseal) begin
			resp_next.rd = req_i.rd;
			resp_next.cap.tag = new_tag;
			resp_next.cap.wide_scope_flag = new_scope;
			resp_next.cap.perms = rs2_perms_clean;
			resp_next.cap.type_label_field = new_type;
			resp_next.cap.base = rs2.base;
			resp_next.cap.top = rs2.top;
			resp_next.cap.addr = rs2.addr;
			resp_next.fail = fail_vec;
			perm_view_next = rs2_perms_clean;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			resp_reg <= CSU_RESP_RESET;
			perm_view_reg <= 64'h0;
		end else begin
			resp_reg <= resp_next;
			perm_view_reg <= perm_view_next;
		end
	end

	assign resp_o = resp_reg;
	assign resp_perm_view_o = perm_view_reg;

endmodule : csu_seal_unit
`default_nettype wire

// ---- csu_seal_unit_sva.sv ----
// Port assertions for the seal and unseal unit
`default_nettype none
module csu_seal_unit_sva import csu_pkg::*; (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire csu_req_s req_i,
	input wire csu_resp_s resp_o,
	input wire logic [CSU_XLEN-1:0] resp_perm_view_o
);
	timeunit 1ns;
	timeprecision 1ps;
	wire logic sl = req_i.valid && req_i.op == CSU_OP_SEAL;
	wire logic us = req_i.valid && req_i.op == CSU_OP_UNSEAL;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	resp_lat_a: assert property (sl || us |=> resp_o.valid)
		else $error("no response");
	seal_type_a: assert property (sl |=>
		resp_o.cap.type_label_field == $past(req_i.rs1.addr[3:0]))
		else $error("type");
	open_type_a: assert property (us |=>
		resp_o.cap.type_label_field == 4'h0) else $error("open type");
	src_sealed_a: assert property (
		sl && req_i.rs2.type_label_field != 4'h0 |=> !resp_o.cap.tag)
		else $error("sealed source");
	grant_miss_a: assert property (
		(sl && !req_i.rs1.perms[CSU_TYPE_LOCK_GRANT_BIT]) ||
		(us && !req_i.rs1.perms[CSU_TYPE_OPEN_GRANT_BIT])
		|=> !resp_o.cap.tag) else $error("missing grant");
	auth_tag_a: assert property ((sl || us) && !req_i.rs1.tag
		|=> !resp_o.cap.tag) else $error("untagged authority");
	exact_type_a: assert property (us && req_i.rs1.addr !=
		{60'h0, req_i.rs2.type_label_field} |=> !resp_o.cap.tag)
		else $error("match");
	perm_view_a: assert property (sl || us |=> resp_perm_view_o ==
		{38'h0, $past(req_i.rs2.perms[25:0])}) else $error("perm view");
	scope_and_a: assert property (us |=> resp_o.cap.wide_scope_flag ==
		($past(req_i.rs1.wide_scope_flag) & $past(req_i.rs2.wide_scope_flag)))
		else $error("scope");
endmodule : csu_seal_unit_sva
bind csu_seal_unit csu_seal_unit_sva chk_u (.clk_i(clk_i), .resetn_i(resetn_i),
	.req_i(req_i), .resp_o(resp_o), .resp_perm_view_o(resp_perm_view_o));
`default_nettype wire

// ---- csu_rf_model.sv ----
// Register file model counting writebacks
`default_nettype none
module csu_rf_model import csu_pkg::*; (
	input wire logic clk_i,
	input wire csu_resp_s resp_i,
	output var logic [31:0] n_wr_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial n_wr_o = 0;
	// Failed checks still write rd
	always @(posedge clk_i) begin
		if (resp_i.valid) n_wr_o <= n_wr_o + 1;
	end
endmodule : csu_rf_model
`default_nettype wire

// ---- tb.sv ----
// Self-checking bench for the seal and unseal unit
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import csu_pkg::*;
	// One expected writeback with its permission view
	typedef struct packed {
		csu_resp_s r;
		logic [CSU_XLEN-1:0] pv;
	} csu_exp_s;
	localparam int EW = $bits(csu_exp_s);
	logic clk_i = 0;
	logic resetn_i = 0;
	csu_req_s req_i = '0;
	csu_resp_s resp_o;
	logic [CSU_XLEN-1:0] pv;
	logic [31:0] n_wr;
	csu_exp_s q[$];
	int n_errors = 0;
	int num_checks = 0;
	int cyc = 0;
	int n_ops = 0;
	always #5 clk_i = ~clk_i;
	csu_seal_unit dut_u (.clk_i(clk_i), .resetn_i(resetn_i), .req_i(req_i),
		.resp_o(resp_o), .resp_perm_view_o(pv));
	csu_rf_model rf_u (.clk_i(clk_i), .resp_i(resp_o), .n_wr_o(n_wr));
	task automatic chk(logic [EW-1:0] seen, logic [EW-1:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
		end
	endtask : chk
	task automatic end_of_test;
		$display("errors %0d checks %0d", n_errors, num_checks);
		if (n_errors == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_of_test
	// Authority spans types lo to 0x11; f holds the expected cause bits
	task automatic send(csu_op_e o, logic [63:0] a, logic [25:0] p,
		logic t1, logic g1, logic [3:0] ty, logic [7:0] f,
		logic [63:0] lo = 64'h0);
		csu_req_s r;
		csu_exp_s e;
		r = '0;
		r.valid = 1'b1;
		r.op = o;
		r.rd = 5'($urandom);
		r.rs1.tag = t1;
		r.rs1.wide_scope_flag = g1;
		r.rs1.perms = {38'h0, p};
		r.rs1.base = lo;
		r.rs1.top = 65'h12;
		r.rs1.addr = a;
		r.rs2.tag = 1'b1;
		r.rs2.wide_scope_flag = 1'($urandom);
		r.rs2.perms = {$urandom, $urandom};
		r.rs2.type_label_field = ty;
		r.rs2.base = {$urandom, $urandom};
		r.rs2.top = {1'b0, $urandom, $urandom};
		r.rs2.addr = {$urandom, $urandom};
		@(posedge clk_i);
		req_i <= r;
		if (o != CSU_OP_NONE) begin
			e = '0;
			e.r.valid = 1'b1;
			e.r.rd = r.rd;
			e.r.cap = r.rs2;
			e.r.cap.tag = (f == 8'h00);
			e.r.cap.perms = {38'h0, r.rs2.perms[25:0]};
			e.r.cap.type_label_field = (o == CSU_OP_SEAL) ? a[3:0] : 4'h0;
			if (o == CSU_OP_UNSEAL) begin
				e.r.cap.wide_scope_flag = g1 & r.rs2.wide_scope_flag;
			end
			e.r.fail = f;
			e.pv = e.r.cap.perms;
			q.push_back(e);
			n_ops++;
		end
	endtask : send
	always @(negedge clk_i) begin
		cyc++;
		if (cyc > 300) begin
			n_errors++;
			end_of_test();
		end else if (resp_o.valid === 1'b1) begin
			if (q.size() == 0)
				chk('1, '0);
			else
				chk({resp_o, pv}, q.pop_front());
		end
	end
	initial begin
		logic [3:0] t;
		void'($urandom(38192));
		repeat (2) @(posedge clk_i);
		resetn_i <= 1'b1;
		t = 4'($urandom_range(15, 2));
		send(CSU_OP_SEAL, {60'h0, t}, 26'h1000000, 1, 1, 4'h0, 8'h00);
		send(CSU_OP_SEAL, 64'h1, 26'h1000000, 1, 1, 4'h0, 8'h00);
		send(CSU_OP_SEAL, {60'h0, t}, 26'h1000000, 1, 1, 4'h3, 8'h01);
		send(CSU_OP_SEAL, {60'h0, t}, 26'h1000000, 0, 1, 4'h0, 8'h02);
		send(CSU_OP_SEAL, {60'h0, t}, 26'h2000000, 1, 1, 4'h0, 8'h04);
		send(CSU_OP_SEAL, 64'h12, 26'h1000000, 1, 1, 4'h0, 8'h30);
		send(CSU_OP_SEAL, 64'h5, 26'h1000000, 1, 1, 4'h0, 8'h10, 64'h6);
		send(CSU_OP_SEAL, 64'h10, 26'h1000000, 1, 1, 4'h0, 8'h20);
		send(CSU_OP_SEAL, 64'h0, 26'h1000000, 1, 1, 4'h0, 8'h20);
		send(CSU_OP_NONE, 64'h0, 26'h0, 1, 1, 4'h0, 8'h00);
		send(CSU_OP_UNSEAL, {60'h0, t}, 26'h2000000, 1, 0, t, 8'h00);
		send(CSU_OP_UNSEAL, {60'h0, t}, 26'h2000000, 1, 1, t, 8'h00);
		send(CSU_OP_UNSEAL, {60'h0, t}, 26'h2000000, 1, 1, ~t, 8'h80);
		send(CSU_OP_UNSEAL, {60'h0, t}, 26'h1000000, 1, 1, t, 8'h08);
		send(CSU_OP_UNSEAL, 64'h12, 26'h2000000, 1, 1, 4'h2, 8'h90);
		send(CSU_OP_UNSEAL, {60'h0, t}, 26'h2000000, 1, 1, t, 8'h10,
			64'h10);
		@(posedge clk_i);
		req_i <= '0;
		repeat (3) @(posedge clk_i);
		chk(EW'(n_wr), EW'(n_ops));
		// Mid-run reset must clear the held result
		resetn_i <= 1'b0;
		@(negedge clk_i);
		chk({resp_o, pv}, '0);
		@(posedge clk_i);
		resetn_i <= 1'b1;
		send(CSU_OP_SEAL, {60'h0, t}, 26'h1000000, 1, 1, 4'h0, 8'h00);
		@(posedge clk_i);
		req_i <= '0;
		repeat (2) @(posedge clk_i);
		chk(EW'(q.size()), EW'(0));
		end_of_test();
	end
endmodule : tb
`default_nettype wire
